//--- design/adc_chain_sequencer.sv
/*
  Conversion chain sequencer: normal and injected chains, cancel requests,
  per-channel completion flags, chain-end interrupt, presample settings.
  Assumes a register master on the same clock that never issues both strobes at once.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_chain_sequencer_cfg.svh"

module adc_chain_sequencer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output logic [3:0] analog_ch_out,
  output logic analog_sample_out,
  output logic analog_convert_out,
  output logic [1:0] presample_ref_out
);
  import adc_chain_sequencer_pkg::*;

  localparam logic [7:0] SAMPLE_LEN = 8'(`SAMPLE_CYC);
  localparam logic [7:0] CONV_LEN = 8'(`CONV_CYC);

  seq_regs_t r, n;
  logic special;
  logic [7:0] samp_len;
  logic conv_last;
  logic start_conv;

  // Lowest pending channel goes first
  function automatic logic [3:0] lowest_ch(input logic [15:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : lowest_ch

  // Channel class and the sample length it takes
  always_comb begin
    special = (r.cur_ch == `SPECIAL_CH_A) || (r.cur_ch == `SPECIAL_CH_B) || (r.cur_ch == `SPECIAL_CH_C);
    if (r.selftest_en) begin
      samp_len = r.selftest_time;
    end else if (special) begin
      samp_len = r.timing_second;
    end else begin
      samp_len = SAMPLE_LEN;
    end
    conv_last = (r.st == ST_CONVERT) && (r.cnt == CONV_LEN - 8'h01);
    start_conv = (r.st == ST_IDLE) && ((r.inj_pend | r.norm_pend) != 16'h0000);
  end

  // Next state: bus access first, then the sequencer, so hardware sets win
  always_comb begin
    n = r;
    n.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `OFS_CTRL: n.rdata = {26'h0, r.selftest_en, 1'b0, r.chain_cancel, r.chan_cancel, r.scan, 1'b0};
        `OFS_NORMAL_MASK: n.rdata = {16'h0, r.norm_mask};
        `OFS_INJECT_MASK: n.rdata = {16'h0, r.inj_mask};
        `OFS_DONE_FLAGS: n.rdata = {16'h0, r.done_flags};
        `OFS_IRQ_STATUS: begin
          n.rdata = {30'h0, r.irq_stat};
          n.irq_stat = 2'h0; // Read clears
        end
        `OFS_IRQ_MASK: n.rdata = {30'h0, r.irq_mask};
        `OFS_PRESAMPLE: n.rdata = {3'h0, r.psc_alt, 24'h0, r.psc_bypass, r.psc_sel};
        `OFS_TIMING_SECOND: n.rdata = {24'h0, r.timing_second};
        `OFS_SELFTEST_TIME: n.rdata = {24'h0, r.selftest_time};
        `OFS_STATUS: n.rdata = {25'h0, r.cur_inj, r.cur_ch, r.st};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        `OFS_CTRL: begin
          n.scan = reg_wdata_in[`CTRL_SCAN_MODE];
          n.selftest_en = reg_wdata_in[`CTRL_SELFTEST_EN];
          // Cancels only count once a chain is running
          if (reg_wdata_in[`CTRL_CHAN_CANCEL] && r.st != ST_IDLE) begin
            n.chan_cancel = 1'b1;
          end
          if (reg_wdata_in[`CTRL_CHAIN_CANCEL] && r.st != ST_IDLE) begin
            n.chain_cancel = 1'b1;
          end
          // Starts while the same chain still runs are dropped
          if (reg_wdata_in[`CTRL_NORMAL_START] && r.norm_pend == 16'h0000) begin
            n.norm_pend = r.norm_mask;
          end
          if (reg_wdata_in[`CTRL_INJECT_START] && r.inj_pend == 16'h0000) begin
            n.inj_pend = r.inj_mask;
          end
        end
        `OFS_NORMAL_MASK: n.norm_mask = reg_wdata_in[15:0];
        `OFS_INJECT_MASK: n.inj_mask = reg_wdata_in[15:0];
        `OFS_DONE_FLAGS: n.done_flags = r.done_flags & ~reg_wdata_in[15:0];
        `OFS_IRQ_MASK: n.irq_mask = reg_wdata_in[1:0];
        `OFS_PRESAMPLE: begin
          n.psc_sel = reg_wdata_in[`PSC_SEL_LSB +: 2];
          n.psc_bypass = reg_wdata_in[`PSC_BYPASS_BIT];
          n.psc_alt = reg_wdata_in[`PSC_ALT_MSB:`PSC_ALT_LSB];
        end
        `OFS_TIMING_SECOND: n.timing_second = reg_wdata_in[7:0];
        `OFS_SELFTEST_TIME: n.selftest_time = reg_wdata_in[7:0];
        default: n.scan = n.scan;
      endcase
    end
    case (r.st)
      ST_IDLE: begin
        if (start_conv) begin
          // Injected work is always picked before normal work
          n.cur_inj = (r.inj_pend != 16'h0000);
          n.cur_ch = (r.inj_pend != 16'h0000) ? lowest_ch(r.inj_pend) : lowest_ch(r.norm_pend);
          n.cnt = 8'h00;
          n.st = r.psc_bypass ? ST_CONVERT : ST_SAMPLE;
        end else begin
          // No work left: a stale cancel must not hit the next chain
          n.chan_cancel = 1'b0;
          n.chain_cancel = 1'b0;
        end
      end
      ST_SAMPLE, ST_CONVERT: begin
        if (r.chain_cancel) begin
          // Whole chain dropped; its end is still reported
          n.chain_cancel = 1'b0;
          n.chan_cancel = 1'b0;
          n.st = ST_IDLE;
          if (r.cur_inj) begin
            n.inj_pend = 16'h0000;
            n.irq_stat[`IRQ_INJECT_END] = 1'b1;
          end else begin
            n.norm_pend = 16'h0000;
            n.irq_stat[`IRQ_NORMAL_END] = 1'b1;
          end
        end else if (r.chan_cancel) begin
          // Dropped channel gets no flag and loses its pending bit; other pending bits stay
          n.chan_cancel = 1'b0;
          n.st = ST_IDLE;
          if (r.cur_inj) begin
            n.inj_pend[r.cur_ch] = 1'b0;
            if ((r.inj_pend & ~(16'h0001 << r.cur_ch)) == 16'h0000) begin
              n.irq_stat[`IRQ_INJECT_END] = 1'b1;
            end
          end else begin
            n.norm_pend[r.cur_ch] = 1'b0;
            if ((r.norm_pend & ~(16'h0001 << r.cur_ch)) == 16'h0000) begin
              n.irq_stat[`IRQ_NORMAL_END] = 1'b1;
            end
          end
        end else if (!r.cur_inj && r.inj_pend != 16'h0000) begin
          // Abort the normal channel; its pending bit stays set so it is redone
          n.st = ST_IDLE;
        end else if (r.st == ST_SAMPLE) begin
          if (({1'b0, r.cnt} + 9'h001) >= {1'b0, samp_len}) begin
            n.st = ST_CONVERT;
            n.cnt = 8'h00;
          end else begin
            n.cnt = r.cnt + 8'h01;
          end
        end else if (conv_last) begin
          n.st = ST_IDLE;
          n.chan_cancel = 1'b0; // Channel ended anyway, so its cancel is spent
          n.done_flags[r.cur_ch] = 1'b1;
          if (r.cur_inj) begin
            n.inj_pend[r.cur_ch] = 1'b0;
            if ((r.inj_pend & ~(16'h0001 << r.cur_ch)) == 16'h0000) begin
              n.irq_stat[`IRQ_INJECT_END] = 1'b1;
            end
          end else begin
            n.norm_pend[r.cur_ch] = 1'b0;
            if ((r.norm_pend & ~(16'h0001 << r.cur_ch)) == 16'h0000) begin
              n.irq_stat[`IRQ_NORMAL_END] = 1'b1;
              if (r.scan) begin
                n.norm_pend = r.norm_mask; // Scan restarts the chain
              end
            end
          end
        end else begin
          n.cnt = r.cnt + 8'h01;
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  // The only state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.selftest_time <= `SELFTEST_TIME_RST;
      r.timing_second <= `TIMING_SECOND_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out = r.rdata;
  assign irq_out = |(r.irq_stat & r.irq_mask);
  assign analog_ch_out = r.cur_ch;
  assign analog_sample_out = (r.st == ST_SAMPLE);
  assign analog_convert_out = (r.st == ST_CONVERT);
  // Channels 9, 10 and 15 take the alternate reference source
  assign presample_ref_out = special ? r.psc_alt : r.psc_sel;

  a_preempt_abort: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (r.st != ST_IDLE && !r.cur_inj && r.inj_pend != 16'h0000 && !r.chan_cancel && !r.chain_cancel)
    |=> (r.st == ST_IDLE) ##1 r.cur_inj)
    else $error("normal channel not pre-empted by injected chain");

  a_restore_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (r.st != ST_IDLE && !r.cur_inj && r.inj_pend != 16'h0000 && !r.chan_cancel && !r.chain_cancel)
    |=> r.norm_pend[$past(r.cur_ch)])
    else $error("aborted normal channel lost its pending bit");

  a_inject_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_conv && r.inj_pend != 16'h0000) |=> r.cur_inj && r.inj_pend[r.cur_ch])
    else $error("injected work not picked first");

  a_flag_on_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (conv_last && !r.chan_cancel && !r.chain_cancel && !(!r.cur_inj && r.inj_pend != 16'h0000))
    |=> r.done_flags[$past(r.cur_ch)])
    else $error("completion flag missing after conversion");

  a_chan_cancel_clr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (r.chan_cancel && !r.chain_cancel && r.st != ST_IDLE && !r.done_flags[r.cur_ch])
    |=> !r.chan_cancel && r.st == ST_IDLE && !r.done_flags[$past(r.cur_ch)])
    else $error("channel cancel not honoured");

  a_chain_cancel_inj: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (r.chain_cancel && r.cur_inj && r.st != ST_IDLE)
    |=> r.inj_pend == 16'h0000 && r.irq_stat[`IRQ_INJECT_END] && !r.chain_cancel)
    else $error("chain cancel left injected chain running");

  a_chain_end_irq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (conv_last && r.cur_inj && $onehot(r.inj_pend) && !r.chan_cancel && !r.chain_cancel)
    |=> r.irq_stat[`IRQ_INJECT_END])
    else $error("no chain-end flag at end of injected chain");

  a_bypass_skip: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_conv && r.psc_bypass) |=> analog_convert_out ##1 (analog_convert_out || r.st == ST_IDLE))
    else $error("sampling not bypassed");

  a_sample_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_conv && !r.psc_bypass && !r.selftest_en && r.inj_pend == 16'h0000 && r.norm_pend == 16'h0001)
    |=> analog_sample_out [*6] ##1 (analog_convert_out || r.st == ST_IDLE))
    else $error("wrong sample length on ordinary channel");

  a_inj_cancel_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (r.chan_cancel && !r.chain_cancel && r.cur_inj && r.st != ST_IDLE && $onehot(r.inj_pend) && !reg_wr_in)
    |=> r.inj_pend == 16'h0000 && r.irq_stat[`IRQ_INJECT_END] && r.norm_pend == $past(r.norm_pend))
    else $error("cancel of last injected channel disturbed the normal chain");

  a_flag_only_real: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !conv_last |=> ((r.done_flags & ~$past(r.done_flags)) == 16'h0000))
    else $error("completion flag set without a finished conversion");

  a_rdata_slot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == `OFS_DONE_FLAGS) |=> reg_rdata_out == {16'h0000, $past(r.done_flags)})
    else $error("completion flags not shown in the read slot");

  a_cancel_idle_clr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (r.st == ST_IDLE && !start_conv) |=> !r.chan_cancel && !r.chain_cancel)
    else $error("cancel request left over after the chains ended");

  // Main scenarios that the bench should reach
  c_scan_reload: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    r.scan && conv_last && !r.cur_inj && $onehot(r.norm_pend));
  c_preempt: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    r.st != ST_IDLE && !r.cur_inj && r.inj_pend != 16'h0000);
  c_inj_cancel: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    r.chan_cancel && r.cur_inj && $onehot(r.inj_pend));
  c_chain_cancel: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    r.chain_cancel && r.cur_inj);
  c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_out));

endmodule : adc_chain_sequencer
`default_nettype wire

//--- design/adc_chain_sequencer_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the chain sequencer.
  Assumes a 10 MHz system clock and byte addresses on the register port.
*/
`ifndef ADC_CHAIN_SEQUENCER_CFG_SVH
`define ADC_CHAIN_SEQUENCER_CFG_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_NORMAL_MASK 8'h04
`define OFS_INJECT_MASK 8'h08
`define OFS_DONE_FLAGS 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_PRESAMPLE 8'h18
`define OFS_TIMING_SECOND 8'h1C
`define OFS_SELFTEST_TIME 8'h20
`define OFS_STATUS 8'h24

// Control register bits
`define CTRL_NORMAL_START 0
`define CTRL_SCAN_MODE 1
`define CTRL_CHAN_CANCEL 2
`define CTRL_CHAIN_CANCEL 3
`define CTRL_INJECT_START 4
`define CTRL_SELFTEST_EN 5

// Interrupt status bits
`define IRQ_NORMAL_END 0
`define IRQ_INJECT_END 1

// Presample control fields
`define PSC_SEL_LSB 0
`define PSC_BYPASS_BIT 2
`define PSC_ALT_LSB 27
`define PSC_ALT_MSB 28
`define REF_GROUND 2'h1

// Channels that take the alternate presample and timing settings
`define SPECIAL_CH_A 4'h9
`define SPECIAL_CH_B 4'hA
`define SPECIAL_CH_C 4'hF

// Reset values
`define SELFTEST_TIME_RST 8'h80
`define TIMING_SECOND_RST 8'h08

// Timing
`define CLK_PERIOD_NS 100
`define SAMPLE_TIME_NS 600
`define CONV_TIME_NS 1000
`define SAMPLE_CYC ((`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- design/adc_chain_sequencer_pkg.sv
/*
  Types of the chain sequencer: state encoding and the packed state record.
  Assumes the constants header sits beside it.
*/
`default_nettype none
package adc_chain_sequencer_pkg;

  // Gray along idle, sample, convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3
  } seq_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [15:0] norm_pend;
    logic [15:0] inj_pend;
    logic [3:0] cur_ch;
    logic cur_inj;
    logic [7:0] cnt;
    logic scan;
    logic selftest_en;
    logic chan_cancel;
    logic chain_cancel;
    logic [15:0] norm_mask;
    logic [15:0] inj_mask;
    logic [15:0] done_flags;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] psc_sel;
    logic psc_bypass;
    logic [1:0] psc_alt;
    logic [7:0] timing_second;
    logic [7:0] selftest_time;
    logic [31:0] rdata;
  } seq_regs_t;

endpackage : adc_chain_sequencer_pkg
`default_nettype wire

//--- bench/adc_chain_sequencer_tb.sv
/*
  Self-checking bench of the chain sequencer: register tasks, chain scenarios, verdict.
  Assumes the design, its package and its constants header are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_chain_sequencer_cfg.svh"

module adc_chain_sequencer_tb;
  import adc_chain_sequencer_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic irq_out;
  logic [3:0] analog_ch_out;
  logic analog_sample_out;
  logic analog_convert_out;
  logic [1:0] presample_ref_out;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int conv_starts = 0;
  int run_len = 0;
  int last_len = 0;
  logic [3:0] seq[$];
  logic [1:0] ref_of[16];
  logic prev_s = 1'b0;
  logic prev_c = 1'b0;
  logic [31:0] rd_val;

  adc_chain_sequencer dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out),
    .analog_ch_out(analog_ch_out),
    .analog_sample_out(analog_sample_out),
    .analog_convert_out(analog_convert_out),
    .presample_ref_out(presample_ref_out)
  );

  // 10 MHz system clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  // Channel attempts, sample lengths and reference per channel; also the hang limit
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    prev_s <= analog_sample_out;
    prev_c <= analog_convert_out;
    if (analog_sample_out && !prev_s) begin
      seq.push_back(analog_ch_out);
    end
    if (analog_sample_out) begin
      run_len <= run_len + 1;
    end else if (prev_s) begin
      last_len <= run_len;
      run_len <= 0;
    end
    if (analog_convert_out && !prev_c) begin
      conv_starts <= conv_starts + 1;
      ref_of[analog_ch_out] <= presample_ref_out;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : cmp

  task automatic chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    rd(a, rd_val);
    cmp(rd_val, exp, msg);
  endtask : chk

  // Bounded wait for a channel in sample (conv=0) or convert (conv=1)
  task automatic wait_ph(input logic [3:0] ch, input logic conv);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk_in);
      #1;
      if ((conv ? analog_convert_out : analog_sample_out) && analog_ch_out === ch) break;
    end
  endtask : wait_ph

  // Idle is one cycle between channels, so four quiet cycles mean the chains are over
  task automatic wait_quiet;
    int i;
    int q;
    q = 0;
    for (i = 0; i < 5000 && q < 4; i++) begin
      @(posedge clk_in);
      #1;
      q = (analog_sample_out || analog_convert_out) ? 0 : q + 1;
    end
  endtask : wait_quiet

  // Sampled channels packed one nibble each, first channel lowest
  task automatic cmp_seq(input logic [31:0] exp, input int n, input string msg);
    logic [31:0] got;
    int i;
    got = 32'h0;
    for (i = 0; i < seq.size() && i < 8; i++) begin
      got[4*i+:4] = seq[i];
    end
    cmp(32'(seq.size()), 32'(n), msg);
    cmp(got, exp, msg);
    seq.delete();
  endtask : cmp_seq

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    int i;
    int n0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk(`OFS_SELFTEST_TIME, 32'h80, "selftest time reset");
    chk(`OFS_TIMING_SECOND, 32'h08, "second timing reset");
    chk(8'h30, 32'h0, "unmapped read");
    chk(`OFS_STATUS, 32'h0, "idle status");
    wr(`OFS_IRQ_MASK, 32'h3);
    $display("test reset done");
    // Injected chain over normal chain ch0..3, injected ch4..6
    wr(`OFS_NORMAL_MASK, 32'h000F);
    wr(`OFS_INJECT_MASK, 32'h0070);
    wr(`OFS_CTRL, 32'h1);
    wait_ph(4'h1, 1'b0);
    wr(`OFS_CTRL, 32'h10);
    wait_quiet();
    cmp_seq(32'h3216_5410, 8, "preempt order");
    chk(`OFS_DONE_FLAGS, 32'h7F, "flags after preempt");
    cmp({31'h0, irq_out}, 32'h1, "irq level");
    chk(`OFS_IRQ_STATUS, 32'h3, "both chain ends");
    cmp({31'h0, irq_out}, 32'h0, "irq after status read");
    $display("test preempt done");
    // Same, but the last injected channel is cancelled while converting
    wr(`OFS_DONE_FLAGS, 32'hFFFF);
    wr(`OFS_CTRL, 32'h1);
    wait_ph(4'h1, 1'b0);
    wr(`OFS_CTRL, 32'h10);
    wait_ph(4'h6, 1'b1);
    wr(`OFS_CTRL, 32'h4);
    chk(`OFS_CTRL, 32'h0, "channel cancel cleared");
    wait_quiet();
    cmp_seq(32'h3216_5410, 8, "cancel keeps restore");
    chk(`OFS_DONE_FLAGS, 32'h3F, "no flag for cancelled");
    chk(`OFS_IRQ_STATUS, 32'h3, "chain ends after cancel");
    $display("test channel cancel done");
    // Chain cancel on a running injected chain ch8..10
    wr(`OFS_DONE_FLAGS, 32'hFFFF);
    wr(`OFS_INJECT_MASK, 32'h0700);
    wr(`OFS_CTRL, 32'h10);
    wait_ph(4'h8, 1'b1);
    wr(`OFS_CTRL, 32'h8);
    wait_quiet();
    cmp_seq(32'h8, 1, "chain cancel stops chain");
    chk(`OFS_CTRL, 32'h0, "chain cancel cleared");
    chk(`OFS_IRQ_STATUS, 32'h2, "injected end flag");
    chk(`OFS_DONE_FLAGS, 32'h0, "no flag for stopped");
    // Cancels written while idle have nothing to act on
    wr(`OFS_CTRL, 32'hC);
    chk(`OFS_CTRL, 32'h0, "idle cancel dropped");
    $display("test chain cancel done");
    // Ground presample with bypass on an ordinary channel; normal end masked
    wr(`OFS_IRQ_MASK, 32'h2);
    wr(`OFS_PRESAMPLE, 32'h5);
    wr(`OFS_NORMAL_MASK, 32'h1);
    n0 = conv_starts;
    wr(`OFS_CTRL, 32'h1);
    wait_quiet();
    cmp_seq(32'h0, 0, "bypass skips sample");
    cmp(32'(conv_starts - n0), 32'h1, "bypass converts once");
    cmp({30'h0, ref_of[0]}, 32'h1, "ground reference");
    chk(`OFS_DONE_FLAGS, 32'h1, "bypass flag");
    cmp({31'h0, irq_out}, 32'h0, "masked normal end");
    chk(`OFS_IRQ_STATUS, 32'h1, "normal end status");
    // Special channel takes the alternate field and second timing, not bypass
    wr(`OFS_PRESAMPLE, 32'h1000_0001);
    wr(`OFS_TIMING_SECOND, 32'h3);
    wr(`OFS_NORMAL_MASK, 32'h0201);
    wr(`OFS_CTRL, 32'h1);
    wait_quiet();
    cmp_seq(32'h90, 2, "alt chain order");
    cmp({30'h0, ref_of[9]}, 32'h2, "alt reference ch9");
    cmp({30'h0, ref_of[0]}, 32'h1, "plain reference ch0");
    cmp(32'(last_len), 32'h3, "second timing length");
    $display("test presample done");
    // Scan reloads the chain after its end; a chain cancel then stops it
    wr(`OFS_DONE_FLAGS, 32'hFFFF);
    wr(`OFS_NORMAL_MASK, 32'h1);
    wr(`OFS_CTRL, 32'h3);
    wait_ph(4'h0, 1'b1);
    wait_ph(4'h0, 1'b0);
    wr(`OFS_CTRL, 32'h8);
    wait_quiet();
    cmp_seq(32'h00, 2, "scan reran chain");
    chk(`OFS_DONE_FLAGS, 32'h1, "scan flags before cancel");
    chk(`OFS_CTRL, 32'h0, "scan chain cancel cleared");
    chk(`OFS_IRQ_STATUS, 32'h1, "scan chain end");
    $display("test scan done");
    // Two step zero runs, each checked, nothing in between
    wr(`OFS_SELFTEST_TIME, 32'hFF);
    chk(`OFS_SELFTEST_TIME, 32'hFF, "selftest time raised");
    wr(`OFS_NORMAL_MASK, 32'h1);
    for (i = 0; i < 2; i++) begin
      wr(`OFS_CTRL, 32'h21);
      wait_quiet();
      cmp(32'(last_len), 32'hFF, "selftest sample length");
    end
    cmp_seq(32'h00, 2, "two step zero runs");
    $display("test selftest done");
    report_and_stop();
  end

endmodule : adc_chain_sequencer_tb

`default_nettype wire
